// >>> hrf_byte_buffer.sv
// Sequential byte buffer
`timescale 1ns/1ps
`default_nettype none
module hrf_byte_buffer #(
    parameter int unsigned DEPTH = 512,
    parameter int unsigned AW    = 9
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    // Control
    input  wire logic          clear_i,
    // Fill side
    input  wire logic          wr_en_i,
    input  wire logic [7:0]    wr_data_i,
    // Drain side
    input  wire logic          rd_en_i,
    output logic      [7:0]    head_o,
    output logic      [AW:0]   fill_o
);
    logic [7:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW-1:0] rd_ptr_next;
    logic [AW:0]   fill_reg;
    logic [AW:0]   fill_next;
    logic          do_wr;
    logic          do_rd;

    // Writes beyond capacity and reads of an empty buffer are dropped
    assign do_wr = wr_en_i && (fill_reg != (AW+1)'(DEPTH));
    assign do_rd = rd_en_i && (fill_reg != '0);

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        fill_next   = fill_reg;
        if (clear_i) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            fill_next   = '0;
        end else begin
            if (do_wr) begin
                wr_ptr_next = wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_next = rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                fill_next = fill_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                fill_next = fill_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg   <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            fill_reg   <= fill_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (do_wr && !clear_i) begin
            mem[wr_ptr_reg] <= wr_data_i;
        end
    end

    assign head_o = mem[rd_ptr_reg];
    assign fill_o = fill_reg;
endmodule
`default_nettype wire

// >>> hrf_host_model.sv
// Host adapter model on the host pins
`timescale 1ns/1ps
`default_nettype none
module hrf_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rd_data_i,
    output logic      [2:0] sel_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] data_o
);
    initial begin
        sel_o = 3'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        data_o = 8'h00;
    end
    // Data settles 3 clocks before the strobe, strobe high and low >=3
    task automatic acc(input logic w, input logic [2:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        sel_o <= a;
        data_o <= d;
        repeat (3) @(posedge clk_i);
        wr_o <= w;
        rd_o <= !w;
        repeat (5) @(posedge clk_i);
        q = rd_data_i;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        // Released bus must not keep showing the last byte
        data_o <= ~d;
        repeat (4) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// >>> hrf_host_port.sv
// Host register file port
`timescale 1ns/1ps
`default_nettype none
`include "hrf_regs.svh"

// Function
// - Command write stores code, starts operation.
// - Location 1 writes fill buffer in order.
// - Location 1 reads drain buffer in order.
// - Locations 2 to 7 read outcomes.
// - Status bits 6 to 0 hold seven flags.
// - Completion flag set on post, cleared by ack.
// - Overlap flag set with completion flag.
// - Interrupt flag set on transfer, cleared by 01.
// - Busy set with command, cleared after copy.
// - Required flag marks pending location 1 access.
// - Direction high: host reads; low: writes.
// - Type high: data; low: control parameters.
// - Packet load moves its exact count, then runs.
// - 512 byte packet store, 512 bytes per load.
// - No new load while a packet loads or runs; a held packet is replaced.
// - Packet steps run in arrival order.
// - Numbers 00 to 3F; only 0 supported.
// - Stop reports 08, 28 or 29.
// - Resumable ends on resume, abort, replace, age.
// - Supplemental status FE when none.
// - Stop device flag 0, 2 or 3.
module hrf_host_port
    import hrf_pkg::*;
#(
    parameter int unsigned BUF_DEPTH     = `HRF_PKT_BYTES,
    parameter int unsigned BUF_AW        = 9,
    parameter int unsigned AGE_W         = 40,
    parameter logic [AGE_W-1:0] RETIRE_CYCLES = AGE_W'(`HRF_RETIRE_CYCLES)
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    // Host pins
    input  wire logic [2:0]             host_location_select_i,
    input  wire logic                   host_write_strobe_i,
    input  wire logic                   host_read_strobe_i,
    input  wire logic [7:0]             host_data_i,
    output logic      [7:0]             host_data_o,
    output logic                        host_data_oe_n_o,
    // Command hand-off to the controller
    output logic                        cmd_valid_o,
    output logic      [7:0]             cmd_code_o,
    output logic      [47:0]            cmd_args_o,
    input  wire logic                   copy_done_i,
    // Outcome posting
    input  wire logic                   post_valid_i,
    input  wire logic                   post_overlap_i,
    input  wire logic [47:0]            post_outcome_i,
    // Block transfer control
    input  wire logic                   xfer_start_i,
    input  wire logic                   xfer_dir_i,
    input  wire logic                   xfer_type_i,
    input  wire logic [9:0]             xfer_len_i,
    input  wire logic                   xfer_irq_en_i,
    output logic                        xfer_done_o,
    // Controller side of the buffer
    input  wire logic                   ctl_rd_i,
    output logic      [7:0]             ctl_rd_data_o,
    input  wire logic                   ctl_wr_i,
    input  wire logic [7:0]             ctl_wr_data_i,
    // Packet handling
    input  wire logic                   pkt_load_i,
    input  wire logic [5:0]             packet_number_i,
    input  wire logic [9:0]             pkt_len_i,
    output logic                        pkt_reject_o,
    output logic                        pkt_ready_o,
    output logic                        pkt_held_o,
    output logic                        pkt_final_o,
    input  wire logic                   pkt_stop_i,
    input  wire hrf_stop_kind_t         pkt_stop_kind_i,
    input  wire logic                   pkt_supp_valid_i,
    input  wire logic [7:0]             pkt_supp_i,
    input  wire logic                   pkt_same_dev_i,
    input  wire logic                   pkt_stop_src_i,
    input  wire logic [7:0]             pkt_stop_select_i,
    input  wire logic                   pkt_resume_i,
    input  wire logic                   pkt_abort_i
);
    // Pin synchronisers: data and select settle long before the strobe
    logic [2:0] sel_s1, sel_s2;
    logic [7:0] din_s1, din_s2;
    logic       wr_s1, wr_s2, wr_s3;
    logic       rd_s1, rd_s2, rd_s3;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sel_s1 <= '0;
            sel_s2 <= '0;
            din_s1 <= '0;
            din_s2 <= '0;
            {wr_s1, wr_s2, wr_s3} <= '0;
            {rd_s1, rd_s2, rd_s3} <= '0;
        end else begin
            sel_s1 <= host_location_select_i;
            sel_s2 <= sel_s1;
            din_s1 <= host_data_i;
            din_s2 <= din_s1;
            {wr_s1, wr_s2, wr_s3} <= {host_write_strobe_i, wr_s1, wr_s2};
            {rd_s1, rd_s2, rd_s3} <= {host_read_strobe_i, rd_s1, rd_s2};
        end
    end

    // State registers
    logic        rfb_reg, rfb_next;
    logic        ccr_reg, ccr_next;
    logic        scf_reg, scf_next;
    logic        bti_reg, bti_next;
    logic        btr_reg, btr_next;
    logic        btd_reg, btd_next;
    logic        btt_reg, btt_next;
    logic [9:0]  left_reg, left_next;
    logic        xdone_reg, xdone_next;
    logic        cvalid_reg, cvalid_next;
    logic [7:0]  ccode_reg, ccode_next;
    logic [7:0]  arg_reg [`HRF_ARG_COUNT];
    logic [7:0]  cargs_reg [`HRF_ARG_COUNT];
    logic [7:0]  out_reg [`HRF_ARG_COUNT];
    logic [7:0]  out_next [`HRF_ARG_COUNT];
    hrf_pkt_state_t pk_reg, pk_next;
    logic [AGE_W-1:0] age_reg, age_next;
    logic        prej_reg, prej_next;
    logic        pfin_reg, pfin_next;
    logic        pready_reg, pready_next;
    logic        pheld_reg, pheld_next;
    logic [7:0]  hdata_reg, hdata_next;
    logic        hoe_n_reg, hoe_n_next;
    logic [7:0]  crd_reg, crd_next;

    // Decoded host accesses
    logic wr_edge, rd_edge;
    logic accept_cmd, host_blk_wr, host_blk_rd;
    logic ack_cmd, clr_bti_cmd;
    logic pkt_ok, pkt_accept, pkt_post, start_x;
    logic [7:0] head_byte, read_mux;
    logic [BUF_AW:0] fill_unused;

    assign wr_edge = wr_s2 && !wr_s3;
    assign rd_edge = rd_s2 && !rd_s3;
    // Command and argument writes while busy are dropped so a copy in progress stays intact
    assign accept_cmd  = wr_edge && (sel_s2 == `HRF_LOC_CMD) && !rfb_reg;
    assign host_blk_wr = wr_edge && (sel_s2 == `HRF_LOC_BLOCK)
                         && btr_reg && !btd_reg;
    assign host_blk_rd = rd_edge && (sel_s2 == `HRF_LOC_BLOCK)
                         && btr_reg && btd_reg;
    assign ack_cmd     = accept_cmd && (din_s2 == `HRF_CMD_ACK);
    assign clr_bti_cmd = accept_cmd && (din_s2 == `HRF_CMD_CLR_BTI);

    assign pkt_ok = (packet_number_i == `HRF_PKT_NUM_OK)
                    && (pkt_len_i != `HRF_RST_LEN)
                    && (pkt_len_i <= `HRF_PKT_MAX_LEN)
                    && ((pk_reg == HRF_PK_IDLE) || (pk_reg == HRF_PK_HOLD))
                    && !btr_reg;
    assign pkt_accept = pkt_load_i && pkt_ok;
    assign pkt_post   = pkt_stop_i && (pk_reg == HRF_PK_RUN);
    assign start_x    = (xfer_start_i && !btr_reg && (xfer_len_i != '0))
                        || pkt_accept;

    hrf_byte_buffer #(
        .DEPTH (BUF_DEPTH),
        .AW    (BUF_AW)
    ) u_buf (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .clear_i   (pkt_accept || (start_x && !xfer_dir_i)),
        .wr_en_i   (host_blk_wr || ctl_wr_i),
        .wr_data_i (host_blk_wr ? din_s2 : ctl_wr_data_i),
        .rd_en_i   (host_blk_rd || ctl_rd_i),
        .head_o    (head_byte),
        .fill_o    (fill_unused)
    );

    // Command, busy and completion flags
    always_comb begin
        cvalid_next = 1'b0;
        ccode_next  = ccode_reg;
        rfb_next    = rfb_reg;
        ccr_next    = ccr_reg;
        scf_next    = scf_reg;
        bti_next    = bti_reg;
        if (accept_cmd) begin
            ccode_next  = din_s2;
            cvalid_next = 1'b1;
        end
        if (accept_cmd) begin
            rfb_next = 1'b1;
        end else if (copy_done_i) begin
            rfb_next = 1'b0;
        end
        if (post_valid_i || pkt_post) begin
            ccr_next = 1'b1;
            scf_next = post_valid_i && post_overlap_i && !pkt_post;
        end else if (ack_cmd) begin
            ccr_next = 1'b0;
            scf_next = 1'b0;
        end
        if (start_x && xfer_irq_en_i) begin
            bti_next = 1'b1;
        end else if (clr_bti_cmd) begin
            bti_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cvalid_reg <= 1'b0;
            ccode_reg  <= `HRF_RST_BYTE;
            rfb_reg    <= 1'b0;
            ccr_reg    <= 1'b0;
            scf_reg    <= 1'b0;
            bti_reg    <= 1'b0;
        end else begin
            cvalid_reg <= cvalid_next;
            ccode_reg  <= ccode_next;
            rfb_reg    <= rfb_next;
            ccr_reg    <= ccr_next;
            scf_reg    <= scf_next;
            bti_reg    <= bti_next;
        end
    end

    // Arguments and their copy taken with the command
    genvar gi;
    generate
        for (gi = 0; gi < `HRF_ARG_COUNT; gi++) begin : g_arg
            logic [7:0] arg_next;
            logic [7:0] carg_next;
            always_comb begin
                arg_next  = arg_reg[gi];
                carg_next = cargs_reg[gi];
                if (wr_edge && !rfb_reg && (sel_s2 == 3'(gi + 2))) begin
                    arg_next = din_s2;
                end
                if (accept_cmd) begin
                    carg_next = arg_reg[gi];
                end
                out_next[gi] = out_reg[gi];
                if (post_valid_i && !pkt_post) begin
                    out_next[gi] = post_outcome_i[gi*8 +: 8];
                end
            end
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    arg_reg[gi]   <= `HRF_RST_BYTE;
                    cargs_reg[gi] <= `HRF_RST_BYTE;
                end else begin
                    arg_reg[gi]   <= arg_next;
                    cargs_reg[gi] <= carg_next;
                end
            end
            assign cmd_args_o[gi*8 +: 8] = cargs_reg[gi];
        end
    endgenerate

    // Outcome registers; a packet stop fills its own layout
    logic [7:0] pk_out [`HRF_ARG_COUNT];
    always_comb begin
        case (pkt_stop_kind_i)
            HRF_STOP_COMPLETE:  pk_out[0] = `HRF_TS_COMPLETE;
            HRF_STOP_RESUMABLE: pk_out[0] = `HRF_TS_RESUMABLE;
            default:            pk_out[0] = `HRF_TS_FATAL;
        endcase
        pk_out[1] = pkt_supp_valid_i ? pkt_supp_i : `HRF_SUPP_NONE;
        pk_out[2] = {6'h00, !pkt_same_dev_i ? `HRF_TDF_NONE
                          : (pkt_stop_src_i ? `HRF_TDF_SRC : `HRF_TDF_DEST)};
        pk_out[3] = pkt_stop_select_i;
        pk_out[4] = `HRF_RST_BYTE;
        pk_out[5] = {2'b00, `HRF_PKT_NUM_OK};
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < `HRF_ARG_COUNT; i++) begin
            if (reset_i) begin
                out_reg[i] <= `HRF_RST_BYTE;
            end else if (pkt_post) begin
                out_reg[i] <= pk_out[i];
            end else begin
                out_reg[i] <= out_next[i];
            end
        end
    end

    // Block transfer engine
    always_comb begin
        btr_next   = btr_reg;
        btd_next   = btd_reg;
        btt_next   = btt_reg;
        left_next  = left_reg;
        xdone_next = 1'b0;
        if (start_x) begin
            btr_next  = 1'b1;
            btd_next  = pkt_accept ? 1'b0 : xfer_dir_i;
            btt_next  = pkt_accept ? 1'b0 : xfer_type_i;
            left_next = pkt_accept ? pkt_len_i : xfer_len_i;
        end else if (host_blk_wr || host_blk_rd) begin
            left_next = left_reg - 1'b1;
            if (left_reg == 10'h001) begin
                btr_next   = 1'b0;
                xdone_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            btr_reg   <= 1'b0;
            btd_reg   <= 1'b0;
            btt_reg   <= 1'b0;
            left_reg  <= `HRF_RST_LEN;
            xdone_reg <= 1'b0;
        end else begin
            btr_reg   <= btr_next;
            btd_reg   <= btd_next;
            btt_reg   <= btt_next;
            left_reg  <= left_next;
            xdone_reg <= xdone_next;
        end
    end

    // Packet life cycle
    always_comb begin
        pk_next   = pk_reg;
        age_next  = age_reg;
        prej_next = pkt_load_i && !pkt_ok;
        pfin_next = 1'b0;
        case (pk_reg)
            HRF_PK_IDLE: begin
                if (pkt_accept) begin
                    pk_next = HRF_PK_LOAD;
                end
            end
            HRF_PK_LOAD: begin
                if (xdone_next) begin
                    pk_next = HRF_PK_RUN;
                end
            end
            HRF_PK_RUN: begin
                if (pkt_stop_i) begin
                    if (pkt_stop_kind_i == HRF_STOP_RESUMABLE) begin
                        pk_next  = HRF_PK_HOLD;
                        age_next = '0;
                    end else begin
                        pk_next   = HRF_PK_IDLE;
                        pfin_next = 1'b1;
                    end
                end
            end
            HRF_PK_HOLD: begin
                age_next = age_reg + 1'b1;
                if (pkt_accept) begin
                    pk_next   = HRF_PK_LOAD;
                    pfin_next = 1'b1;
                end else if (pkt_resume_i) begin
                    pk_next = HRF_PK_RUN;
                end else if (pkt_abort_i
                             || (age_reg >= RETIRE_CYCLES - 1'b1)) begin
                    pk_next   = HRF_PK_IDLE;
                    pfin_next = 1'b1;
                end
            end
            default: begin
                pk_next = HRF_PK_IDLE;
            end
        endcase
        pready_next = (pk_next == HRF_PK_RUN);
        pheld_next  = (pk_next != HRF_PK_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pk_reg     <= HRF_PK_IDLE;
            age_reg    <= '0;
            prej_reg   <= 1'b0;
            pfin_reg   <= 1'b0;
            pready_reg <= 1'b0;
            pheld_reg  <= 1'b0;
        end else begin
            pk_reg     <= pk_next;
            age_reg    <= age_next;
            prej_reg   <= prej_next;
            pfin_reg   <= pfin_next;
            pready_reg <= pready_next;
            pheld_reg  <= pheld_next;
        end
    end

    // Host read path: value caught at the strobe edge and held
    always_comb begin
        case (sel_s2)
            `HRF_LOC_CMD: read_mux = {1'b0, ccr_reg, scf_reg, bti_reg,
                                      rfb_reg, btr_reg, btd_reg, btt_reg};
            `HRF_LOC_BLOCK: read_mux = head_byte;
            default: read_mux = out_reg[3'(sel_s2 - `HRF_LOC_ARG0)];
        endcase
        hdata_next = hdata_reg;
        hoe_n_next = !rd_s2;
        if (rd_edge) begin
            hdata_next = read_mux;
        end
        crd_next = ctl_rd_i ? head_byte : crd_reg;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hdata_reg <= `HRF_RST_BYTE;
            hoe_n_reg <= 1'b1;
            crd_reg   <= `HRF_RST_BYTE;
        end else begin
            hdata_reg <= hdata_next;
            hoe_n_reg <= hoe_n_next;
            crd_reg   <= crd_next;
        end
    end

    assign host_data_o      = hdata_reg;
    assign host_data_oe_n_o = hoe_n_reg;
    assign cmd_valid_o      = cvalid_reg;
    assign cmd_code_o       = ccode_reg;
    assign xfer_done_o      = xdone_reg;
    assign ctl_rd_data_o    = crd_reg;
    assign pkt_reject_o     = prej_reg;
    assign pkt_ready_o      = pready_reg;
    assign pkt_held_o       = pheld_reg;
    assign pkt_final_o      = pfin_reg;
endmodule
`default_nettype wire

// >>> hrf_host_port_asserts.sv
// Checker for the host register file port
`timescale 1ns/1ps
`default_nettype none
module hrf_host_port_asserts
    import hrf_pkg::*;
(
    input wire logic           clk_i,
    input wire logic           reset_i,
    input wire logic [2:0]     host_location_select_i,
    input wire logic           host_write_strobe_i,
    input wire logic           host_read_strobe_i,
    input wire logic [7:0]     host_data_i,
    input wire logic           host_data_oe_n_o,
    input wire logic           cmd_valid_o,
    input wire logic [7:0]     cmd_code_o,
    input wire logic           xfer_done_o,
    input wire logic           pkt_load_i,
    input wire logic [5:0]     packet_number_i,
    input wire logic [9:0]     pkt_len_i,
    input wire logic           pkt_reject_o,
    input wire logic           pkt_ready_o,
    input wire logic           pkt_held_o,
    input wire logic           pkt_final_o,
    input wire logic           pkt_stop_i,
    input wire hrf_stop_kind_t pkt_stop_kind_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_cmd_src;
        cmd_valid_o |-> $past(host_write_strobe_i, 2)
            && $past(host_location_select_i, 2) == 3'h0;
    endproperty
    a_cmd_src: assert property (p_cmd_src) else $error("command w/o write");
    property p_cmd_code;
        cmd_valid_o |-> cmd_code_o == $past(host_data_i, 2);
    endproperty
    a_cmd_code: assert property (p_cmd_code) else $error("bad code");
    property p_cmd_pulse;
        cmd_valid_o |=> !cmd_valid_o;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("long start");
    property p_done_pulse;
        $rose(xfer_done_o) |=> !xfer_done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("long done");
    property p_rej_busy;
        pkt_load_i && pkt_ready_o |=> pkt_reject_o;
    endproperty
    a_rej_busy: assert property (p_rej_busy) else $error("load taken");
    property p_rej_num;
        pkt_load_i && packet_number_i != 6'h00 |=> pkt_reject_o;
    endproperty
    a_rej_num: assert property (p_rej_num) else $error("number taken");
    property p_rej_len;
        pkt_load_i && pkt_len_i > 10'h200 |=> pkt_reject_o;
    endproperty
    a_rej_len: assert property (p_rej_len) else $error("length taken");
    property p_hold;
        pkt_stop_i && pkt_ready_o && pkt_stop_kind_i == HRF_STOP_RESUMABLE
            |=> pkt_held_o && !pkt_final_o;
    endproperty
    a_hold: assert property (p_hold) else $error("resumable ended");
    property p_oe;
        !host_read_strobe_i [*5] |-> host_data_oe_n_o;
    endproperty
    a_oe: assert property (p_oe) else $error("drives when idle");
endmodule
bind hrf_host_port hrf_host_port_asserts hrf_host_port_asserts_i (.*);
`default_nettype wire

// >>> hrf_host_port_tb.sv
// Self-checking bench for the host register file port
`timescale 1ns/1ps
`default_nettype none
module hrf_host_port_tb;
    import hrf_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1;
    logic [2:0] host_location_select_i;
    logic host_write_strobe_i, host_read_strobe_i, host_data_oe_n_o;
    logic [7:0] host_data_i, host_data_o, cmd_code_o, ctl_rd_data_o, q;
    logic [47:0] cmd_args_o, post_outcome_i = '0;
    logic cmd_valid_o, xfer_done_o, pkt_reject_o, pkt_ready_o;
    logic pkt_held_o, pkt_final_o, copy_done_i = 0, post_valid_i = 0;
    logic post_overlap_i = 0, xfer_start_i = 0, xfer_dir_i = 0;
    logic xfer_type_i = 0, xfer_irq_en_i = 0, ctl_rd_i = 0, ctl_wr_i = 0;
    logic pkt_load_i = 0, pkt_stop_i = 0, pkt_supp_valid_i = 0;
    logic pkt_same_dev_i = 0, pkt_stop_src_i = 0, pkt_resume_i = 0;
    logic pkt_abort_i = 0;
    logic [9:0] xfer_len_i = '0, pkt_len_i = '0;
    logic [7:0] ctl_wr_data_i = '0, pkt_supp_i = '0, pkt_stop_select_i = '0;
    logic [5:0] packet_number_i = '0;
    hrf_stop_kind_t pkt_stop_kind_i = HRF_STOP_COMPLETE;
    int bad_count = 0, total_checks = 0, n;
    always #4 clk_i = ~clk_i;
    hrf_host_port #(.RETIRE_CYCLES(40'd5000)) hrf_host_port_i (.*);
    hrf_host_model hrf_host_model_i (.clk_i(clk_i), .rd_data_i(host_data_o),
        .sel_o(host_location_select_i), .wr_o(host_write_strobe_i),
        .rd_o(host_read_strobe_i), .data_o(host_data_i));
    task automatic test_done;
        $display("Checks %0d, errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        hrf_host_model_i.acc(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        hrf_host_model_i.acc(1'b1, a, d, q);
    endtask
    // Copy done before the next host write
    task automatic cmd(input logic [7:0] c);
        wr(3'h0, c);
        @(posedge clk_i) copy_done_i <= 1'b1;
        @(posedge clk_i) copy_done_i <= 1'b0;
    endtask
    task automatic s_cmd;
        for (int i = 0; i < 6; i++)
            wr(3'(i + 2), 8'(8'h11 * (i + 1)));
        wr(3'h0, 8'h3A);
        chk(cmd_code_o, 8'h3A);
        chk(cmd_args_o[47:40], 8'h66);
        rd(3'h0, 8'h08);
        @(posedge clk_i) copy_done_i <= 1'b1;
        @(posedge clk_i) copy_done_i <= 1'b0;
        post_valid_i <= 1'b1;
        post_overlap_i <= 1'b1;
        post_outcome_i <= 48'hF5F4_F3F2_F1F0;
        @(posedge clk_i) post_valid_i <= 1'b0;
        post_overlap_i <= 1'b0;
        rd(3'h0, 8'h60);
        for (int i = 0; i < 6; i++)
            rd(3'(i + 2), 8'(8'hF0 + i));
        cmd(8'h00);
        rd(3'h0, 8'h00);
    endtask
    task automatic s_pkt;
        @(posedge clk_i) pkt_load_i <= 1'b1;
        packet_number_i <= 6'h01;
        @(posedge clk_i) packet_number_i <= 6'h00;
        pkt_len_i <= 10'h201;
        @(posedge clk_i) pkt_len_i <= 10'h003;
        @(posedge clk_i) pkt_load_i <= 1'b0;
        rd(3'h0, 8'h04);
        for (int i = 0; i < 3; i++)
            wr(3'h1, 8'(8'hC1 + i));
        chk({7'h00, pkt_ready_o}, 8'h01);
        @(posedge clk_i) pkt_load_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i) pkt_load_i <= 1'b0;
            ctl_rd_i <= 1'b1;
            @(posedge clk_i) ctl_rd_i <= 1'b0;
            #1 chk(ctl_rd_data_o, 8'(8'hC1 + i));
        end
        @(posedge clk_i) pkt_stop_i <= 1'b1;
        pkt_stop_kind_i <= HRF_STOP_RESUMABLE;
        pkt_same_dev_i <= 1'b1;
        pkt_stop_src_i <= 1'b1;
        pkt_stop_select_i <= 8'h3C;
        @(posedge clk_i) pkt_stop_i <= 1'b0;
        rd(3'h2, 8'h28);
        rd(3'h3, 8'hFE);
        rd(3'h4, 8'h03);
        rd(3'h5, 8'h3C);
        rd(3'h7, 8'h00);
        rd(3'h0, 8'h40);
        @(posedge clk_i) pkt_abort_i <= 1'b1;
        @(posedge clk_i) pkt_abort_i <= 1'b0;
        for (n = 0; n < 20 && pkt_final_o !== 1'b1; n++) #8;
        chk({7'h00, pkt_final_o}, 8'h01);
        cmd(8'h00);
    endtask
    task automatic s_xfer;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i) ctl_wr_i <= 1'b1;
            ctl_wr_data_i <= 8'(8'h5A + i);
        end
        @(posedge clk_i) ctl_wr_i <= 1'b0;
        {xfer_start_i, xfer_dir_i, xfer_type_i, xfer_irq_en_i} <= 4'hF;
        xfer_len_i <= 10'h002;
        @(posedge clk_i) xfer_start_i <= 1'b0;
        rd(3'h0, 8'h17);
        rd(3'h1, 8'h5A);
        rd(3'h1, 8'h5B);
        rd(3'h0, 8'h13);
        cmd(8'h01);
        rd(3'h0, 8'h03);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        s_cmd();
        s_pkt();
        s_xfer();
        test_done();
    end
endmodule
`default_nettype wire

// >>> hrf_pkg.sv
// Types shared by the host register file port
package hrf_pkg;

    typedef enum logic [3:0] {
        HRF_PK_IDLE = 4'b0001,
        HRF_PK_LOAD = 4'b0010,
        HRF_PK_RUN  = 4'b0100,
        HRF_PK_HOLD = 4'b1000
    } hrf_pkt_state_t;

    typedef enum logic [1:0] {
        HRF_STOP_COMPLETE  = 2'b00,
        HRF_STOP_RESUMABLE = 2'b01,
        HRF_STOP_FATAL     = 2'b10
    } hrf_stop_kind_t;

endpackage

// >>> hrf_regs.svh
// Register locations, status bits, codes and timing
`ifndef HRF_REGS_SVH
`define HRF_REGS_SVH

// Host locations (three select lines)
`define HRF_LOC_CMD         3'h0
`define HRF_LOC_BLOCK       3'h1
`define HRF_LOC_ARG0        3'h2
`define HRF_ARG_COUNT       6

// Status byte bit positions
`define HRF_ST_UNDEF        7
`define HRF_ST_CCR          6
`define HRF_ST_SCF          5
`define HRF_ST_BTI          4
`define HRF_ST_RFB          3
`define HRF_ST_BTR          2
`define HRF_ST_BTD          1
`define HRF_ST_BTT          0

// Reset values
`define HRF_RST_BYTE        8'h00
`define HRF_RST_LEN         10'h000

// Command codes handled by the port itself
`define HRF_CMD_ACK         8'h00
`define HRF_CMD_CLR_BTI     8'h01

// Packet storage and numbering
`define HRF_PKT_BYTES       512
`define HRF_PKT_MAX_LEN     10'h200
`define HRF_PKT_NUM_MAX     6'h3F
`define HRF_PKT_NUM_OK      6'h00

// Packet stop reporting
`define HRF_TS_COMPLETE     8'h08
`define HRF_TS_RESUMABLE    8'h28
`define HRF_TS_FATAL        8'h29
`define HRF_SUPP_NONE       8'hFE
`define HRF_TDF_DEST        2'h0
`define HRF_TDF_NONE        2'h2
`define HRF_TDF_SRC         2'h3

// Retirement of a resumable packet: 15 minutes at 125 MHz
`define HRF_RETIRE_MIN      64'd15
`define HRF_SEC_PER_MIN     64'd60
`define HRF_CLK_HZ          64'd125000000
`define HRF_RETIRE_CYCLES   (`HRF_RETIRE_MIN * `HRF_SEC_PER_MIN * `HRF_CLK_HZ)

`endif
